// ==== opc_psram_cfg.sv ====
// configuration registers and power states of an octal psram device
// assumes a transaction engine on sys_clk that reports the bus phase and
// drives the register port; pins arrive asynchronously
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1: power-down bit cleared enters power down, stops refresh
// RULE2: array contents invalid after leaving power down
// RULE3: select pulse, power-on or hardware reset exits
// RULE4: power down watches only select and reset
// RULE5: host writes ones to upper reserved bits
// RULE6: bit 7 selects linear or wrapped burst
// RULE7: bit 6 selects single-ended or differential clock
// RULE8: single-ended mode ignores complementary clock input
// RULE9: host drives complementary clock in differential mode
// RULE10: writing bit 5 enters hybrid sleep
// RULE11: select low exits sleep, clears sleep bit
// RULE12: resets end sleep but disable refresh
// RULE13: bits 4:2 restrict refresh region
// RULE14: bits 1:0 read-only report refresh interval
// RULE15: refresh only between array accesses
// RULE16: pending refresh drives strobe high during command
// RULE17: host keeps select low under interval limit
// RULE18: read latency drives strobe low, data released
// RULE19: write latency releases data and strobe
// RULE20: zero-latency write: device strobe, no masking
// RULE21: hybrid sleep keeps array and registers
// RULE22: fixed latency always drives strobe high
module opc_psram_cfg
    import opc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic cs_pin_n,
    input wire logic ck_pin,
    input wire logic ck_n_pin,
    input wire logic hw_reset_pin_n,
    input wire logic high_temp,
    input wire opc_phase_e phase,
    input wire logic rd_strobe,
    output logic rwds_out,
    output logic rwds_oe,
    output logic dq_oe,
    output logic ck_rise,
    output logic ck_n_enable,
    output logic burst_linear,
    output logic clock_single,
    output logic [2:0] refresh_region,
    output logic refresh_strobe,
    output logic refresh_busy,
    output logic latency_double,
    output logic deep_power_down,
    output logic hybrid_sleep,
    output logic array_valid
);
    localparam int A_DPD_MAX = DPD_ENTRY_CYC + 2;

    logic [1:0] ctl_lvl, ctl_rise, ctl_fall, ck_lvl;
    logic cs_low, cs_fall, cs_rise, hw_rst_act;
    opc_pwr_e pwr_reg;
    logic [9:0] dpd_cnt_reg;
    logic cs_seen_low_reg, refresh_halt_reg, array_valid_reg;
    logic cfg0_pd_reg, cfg0_fixlat_reg;
    logic [7:0] cfg1_rsvd_reg;
    logic cfg1_burst_reg, cfg1_single_reg, cfg1_sleep_reg;
    logic [2:0] cfg1_par_reg;
    logic [1:0] intv_code;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic dpd_exit, reinit, wr_ok, wr0, wr1, in_pd;
    logic refresh_en, refresh_pending;
    opc_phase_e phase_prev_reg;
    logic ca_start, lat_reg, lat_now;
    logic rwds_out_reg, rwds_oe_reg, dq_oe_reg;
    logic rwds_out_next, rwds_oe_next, dq_oe_next;
    logic ck_gate, ck_gate_prev_reg, ck_rise_reg;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    opc_pin_sync #(.W(2), .RST_VAL(2'h3)) u_ctl_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin({hw_reset_pin_n, cs_pin_n}),
        .lvl(ctl_lvl),
        .rise(ctl_rise),
        .fall(ctl_fall)
    );

    opc_pin_sync #(.W(2), .RST_VAL(2'h2)) u_ck_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin({ck_n_pin, ck_pin}),
        .lvl(ck_lvl),
        .rise(),
        .fall()
    );

    assign cs_low = !ctl_lvl[0];
    assign cs_fall = ctl_fall[0];
    assign cs_rise = ctl_rise[0];
    assign hw_rst_act = !ctl_lvl[1];

    ////////////////////////////////////////////////////////////////////////////
    // power state
    assign in_pd = (pwr_reg == PS_DPD) || (pwr_reg == PS_DPD_ENTRY);
    // the rise that ends the entering write is not an exit pulse
    assign dpd_exit = in_pd && cs_rise && cs_seen_low_reg; // RULE3
    assign reinit = hw_rst_act || dpd_exit; // RULE3 RULE12
    // register writes are ignored in power down; only select and reset count
    assign wr_ok = reg_wr && !in_pd && !hw_rst_act; // RULE4
    assign wr0 = wr_ok && (reg_addr == CFG0_ADDR);
    assign wr1 = wr_ok && (reg_addr == CFG1_ADDR);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || reinit)
        begin
            pwr_reg <= PS_ACTIVE;
            dpd_cnt_reg <= 10'h000;
        end
        else
        begin
            case (pwr_reg)
                PS_ACTIVE:
                begin
                    dpd_cnt_reg <= 10'h000;
                    if (!cfg0_pd_reg)
                        pwr_reg <= PS_DPD_ENTRY; // RULE1
                    else if (cfg1_sleep_reg && !cs_low)
                        pwr_reg <= PS_SLEEP; // RULE10
                end
                PS_DPD_ENTRY:
                begin
                    dpd_cnt_reg <= dpd_cnt_reg + 10'h001;
                    if (dpd_cnt_reg == 10'(DPD_ENTRY_CYC - 1))
                        pwr_reg <= PS_DPD; // RULE1
                end
                PS_DPD:
                    pwr_reg <= PS_DPD;
                PS_SLEEP:
                    if (cs_fall)
                        pwr_reg <= PS_ACTIVE; // RULE11
                default:
                    pwr_reg <= PS_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !in_pd)
            cs_seen_low_reg <= 1'b0;
        else if (cs_fall)
            cs_seen_low_reg <= 1'b1;
    end

    // a reset leaves refresh off until the next access begins
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || hw_rst_act)
            refresh_halt_reg <= 1'b1; // RULE12
        else if (cs_fall)
            refresh_halt_reg <= 1'b0;
    end

    // contents count as lost from power down or reset until rewritten
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || reinit || pwr_reg == PS_DPD)
            array_valid_reg <= 1'b0; // RULE2 RULE12
        else if (phase == PH_WR_DATA || phase == PH_WR_ZERO)
            array_valid_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; power-down exit restores power-on values
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || reinit)
        begin
            cfg0_pd_reg <= CFG0_PD_RST;
            cfg0_fixlat_reg <= CFG0_FIXLAT_RST;
        end
        else if (wr0)
        begin
            cfg0_pd_reg <= reg_wdata[CFG0_PD_BIT]; // RULE1
            cfg0_fixlat_reg <= reg_wdata[CFG0_FIXLAT_BIT]; // RULE22
        end
    end

    // sleep contents survive: nothing here clears on entering sleep
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || reinit)
        begin
            cfg1_rsvd_reg <= CFG1_RSVD_RST; // RULE5
            cfg1_burst_reg <= CFG1_BURST_RST;
            cfg1_single_reg <= CFG1_CLK_RST;
            cfg1_par_reg <= CFG1_PAR_RST;
        end
        else if (wr1)
        begin
            // stored as written; the host is expected to keep them all ones
            cfg1_rsvd_reg <= reg_wdata[CFG1_RSVD_HI:CFG1_RSVD_LO]; // RULE5
            cfg1_burst_reg <= reg_wdata[CFG1_BURST_BIT]; // RULE6
            cfg1_single_reg <= reg_wdata[CFG1_CLK_BIT]; // RULE7
            cfg1_par_reg <= reg_wdata[CFG1_PAR_HI:CFG1_PAR_LO]; // RULE13
        end
    end

    // a write in the same cycle as the select fall wins over the clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || reinit)
            cfg1_sleep_reg <= CFG1_SLEEP_RST; // RULE12
        else if (wr1)
            cfg1_sleep_reg <= reg_wdata[CFG1_SLEEP_BIT]; // RULE10
        else if (pwr_reg == PS_SLEEP && cs_fall)
            cfg1_sleep_reg <= 1'b0; // RULE11
    end

    // read-only interval code follows the temperature grade
    assign intv_code = high_temp ? INTV_1US : INTV_4US; // RULE14

    always_comb
    begin
        rdata_next = '0;
        if (reg_rd)
        begin
            if (reg_addr == CFG0_ADDR)
            begin
                rdata_next[CFG0_PD_BIT] = cfg0_pd_reg;
                rdata_next[CFG0_FIXLAT_BIT] = cfg0_fixlat_reg;
            end
            else if (reg_addr == CFG1_ADDR)
                rdata_next = {cfg1_rsvd_reg, cfg1_burst_reg, cfg1_single_reg, cfg1_sleep_reg,
                              cfg1_par_reg, intv_code}; // RULE14
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // self refresh
    // sleep keeps refreshing so the array is retained
    assign refresh_en = (pwr_reg == PS_ACTIVE || pwr_reg == PS_SLEEP) && !refresh_halt_reg
                        && !hw_rst_act && (cfg1_par_reg != PAR_NONE); // RULE1 RULE13 RULE21

    opc_refresh u_refresh (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .enable(refresh_en),
        .short_sel(high_temp),
        .access(cs_low),
        .pending(refresh_pending),
        .busy(refresh_busy),
        .strobe(refresh_strobe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock input; complementary input only counts in differential mode
    assign ck_gate = ck_lvl[0] && (cfg1_single_reg || !ck_lvl[1]); // RULE8

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ck_gate_prev_reg <= 1'b0;
            ck_rise_reg <= 1'b0;
        end
        else
        begin
            ck_gate_prev_reg <= ck_gate;
            ck_rise_reg <= ck_gate && !ck_gate_prev_reg && pwr_reg == PS_ACTIVE; // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobe and data pin drive per bus phase
    assign ca_start = (phase == PH_CA) && (phase_prev_reg != PH_CA);
    assign lat_now = ca_start ? (cfg0_fixlat_reg || refresh_pending) : lat_reg; // RULE16 RULE22

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            phase_prev_reg <= PH_IDLE;
            lat_reg <= 1'b0;
        end
        else
        begin
            phase_prev_reg <= phase;
            lat_reg <= lat_now;
        end
    end

    always_comb
    begin
        rwds_out_next = 1'b0;
        rwds_oe_next = 1'b0;
        dq_oe_next = 1'b0;
        if (pwr_reg == PS_ACTIVE && !hw_rst_act && cs_low)
        begin
            case (phase)
                PH_CA:
                begin
                    rwds_oe_next = 1'b1;
                    rwds_out_next = lat_now; // RULE16 RULE22
                end
                PH_RD_LAT:
                    rwds_oe_next = 1'b1; // RULE18
                PH_RD_DATA:
                begin
                    rwds_oe_next = 1'b1;
                    rwds_out_next = rd_strobe;
                    dq_oe_next = 1'b1;
                end
                PH_WR_ZERO:
                    rwds_oe_next = 1'b1; // RULE20
                default:
                    rwds_oe_next = 1'b0; // RULE19
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rwds_out_reg <= 1'b0;
            rwds_oe_reg <= 1'b0;
            dq_oe_reg <= 1'b0;
        end
        else
        begin
            rwds_out_reg <= rwds_out_next;
            rwds_oe_reg <= rwds_oe_next;
            dq_oe_reg <= dq_oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = rdata_reg;
    assign rwds_out = rwds_out_reg;
    assign rwds_oe = rwds_oe_reg;
    assign dq_oe = dq_oe_reg;
    assign ck_rise = ck_rise_reg;
    assign ck_n_enable = !cfg1_single_reg; // RULE7 RULE8
    assign burst_linear = cfg1_burst_reg; // RULE6
    assign clock_single = cfg1_single_reg;
    assign refresh_region = cfg1_par_reg; // RULE13
    assign latency_double = lat_reg;
    assign deep_power_down = pwr_reg == PS_DPD;
    assign hybrid_sleep = pwr_reg == PS_SLEEP;
    assign array_valid = array_valid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_dpd_entry_time: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE1
        (wr0 && !reg_wdata[CFG0_PD_BIT] && pwr_reg == PS_ACTIVE && !cs_rise && !hw_rst_act
         && ctl_lvl[1] && !(cs_low && ctl_rise[0]))
        |-> ##[1:A_DPD_MAX] (pwr_reg == PS_DPD || reinit))
        else $error("power down not reached in entry time");

    a_dpd_no_refresh: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE1
        (pwr_reg == PS_DPD) |-> !refresh_busy)
        else $error("refresh running in power down");

    a_dpd_exit_invalid: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE2
        (in_pd && dpd_exit) |=> (pwr_reg == PS_ACTIVE && !array_valid_reg && cfg0_pd_reg))
        else $error("power down exit left state or contents valid");

    a_dpd_pins_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE4
        (pwr_reg == PS_DPD) [*2] |-> (!rwds_oe_reg && !dq_oe_reg && !ck_rise_reg))
        else $error("pins driven or clock seen in power down");

    a_sleep_cs_exit: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE11
        (pwr_reg == PS_SLEEP && cs_fall && !wr1 && !reinit)
        |=> (pwr_reg == PS_ACTIVE && !cfg1_sleep_reg))
        else $error("select low did not end sleep");

    a_interval_code: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE14
        (reg_rd && reg_addr == CFG1_ADDR)
        |=> (rdata_reg[1:0] == ($past(high_temp) ? INTV_1US : INTV_4US)))
        else $error("interval code wrong");

    a_ca_flag_high: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE16 RULE22
        (ca_start && pwr_reg == PS_ACTIVE && cs_low && !hw_rst_act
         && (cfg0_fixlat_reg || refresh_pending))
        |=> (rwds_oe_reg && rwds_out_reg) ##1 (lat_reg || phase_prev_reg != PH_CA))
        else $error("strobe not high during command with extra latency");

    a_rd_lat_low: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE18
        (phase == PH_RD_LAT && pwr_reg == PS_ACTIVE && cs_low && !hw_rst_act)
        |=> (rwds_oe_reg && !rwds_out_reg && !dq_oe_reg))
        else $error("read latency pin drive wrong");

    a_wr_lat_release: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE19
        (phase == PH_WR_LAT || phase == PH_WR_DATA) |=> (!rwds_oe_reg && !dq_oe_reg))
        else $error("device drove pins in write latency");

    a_single_ckn_off: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE8
        (cfg1_single_reg && ck_lvl[0] && !ck_gate_prev_reg && pwr_reg == PS_ACTIVE)
        |=> ck_rise_reg)
        else $error("complementary clock affected single-ended mode");
endmodule // opc_psram_cfg

// ==== opc_pkg.sv ====
// constants, field layout and state types of the octal psram configuration block
// assumes a 100 MHz system clock and a 16-bit register port
package opc_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // register addresses on the plain register port
    localparam logic [3:0] CFG0_ADDR = 4'h0;
    localparam logic [3:0] CFG1_ADDR = 4'h1;

    // config_register_zero fields held here
    localparam int CFG0_PD_BIT = 15;
    localparam int CFG0_FIXLAT_BIT = 3;
    localparam logic CFG0_PD_RST = 1'b1;
    localparam logic CFG0_FIXLAT_RST = 1'b1;

    // config_register_one fields
    localparam int CFG1_RSVD_HI = 15;
    localparam int CFG1_RSVD_LO = 8;
    localparam int CFG1_BURST_BIT = 7;
    localparam int CFG1_CLK_BIT = 6;
    localparam int CFG1_SLEEP_BIT = 5;
    localparam int CFG1_PAR_HI = 4;
    localparam int CFG1_PAR_LO = 2;
    localparam logic [7:0] CFG1_RSVD_RST = 8'hff;
    localparam logic CFG1_BURST_RST = 1'b1;
    localparam logic CFG1_CLK_RST = 1'b1;
    localparam logic CFG1_SLEEP_RST = 1'b0;
    localparam logic [2:0] CFG1_PAR_RST = 3'h0;
    localparam logic [2:0] PAR_NONE = 3'h4;
    localparam logic [1:0] INTV_4US = 2'h1;
    localparam logic [1:0] INTV_1US = 2'h2;

    // times and derived cycle counts (longest times round down)
    localparam int CLK_MHZ = 100;
    localparam int REFRESH_LONG_NS = 4000;
    localparam int REFRESH_SHORT_NS = 1000;
    localparam int DPD_ENTRY_NS = 3000;
    localparam int REFRESH_LONG_CYC = REFRESH_LONG_NS * CLK_MHZ / 1000;
    localparam int REFRESH_SHORT_CYC = REFRESH_SHORT_NS * CLK_MHZ / 1000;
    localparam int DPD_ENTRY_CYC = DPD_ENTRY_NS * CLK_MHZ / 1000;
    localparam int REFRESH_BUSY_CYC = 8;

    // bus phase reported by the transaction engine
    typedef enum logic [2:0] {PH_IDLE, PH_CA, PH_RD_LAT, PH_WR_LAT, PH_RD_DATA, PH_WR_DATA,
                              PH_WR_ZERO} opc_phase_e;

    typedef enum logic [1:0] {PS_ACTIVE, PS_DPD_ENTRY, PS_DPD, PS_SLEEP} opc_pwr_e;

endpackage

// ==== opc_pin_sync.sv ====
// three-flop synchroniser for pins from outside the sys_clk domain
// a change counts once the second and third flops agree
`timescale 1ns/10ps
module opc_pin_sync
    import opc_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg, fall_reg;
    logic [W-1:0] lvl_next;

    if (W < 1)
    begin : g_chk
        $error("opc_pin_sync width must be at least one");
    end

    // disagreement keeps the old level, filtering a single-sample glitch
    assign lvl_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            lvl_reg <= RST_VAL;
            rise_reg <= '0;
            fall_reg <= '0;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            rise_reg <= lvl_next & ~lvl_reg;
            fall_reg <= ~lvl_next & lvl_reg;
        end
    end

    assign lvl = lvl_reg;
    assign rise = rise_reg;
    assign fall = fall_reg;
endmodule // opc_pin_sync

// ==== opc_refresh.sv ====
// distributed self-refresh timer and arbiter
// access is the chip-select-low level from the synchronised pin
`timescale 1ns/10ps
module opc_refresh
    import opc_pkg::*;
#(
    parameter int INTERVAL_LONG = REFRESH_LONG_CYC,
    parameter int INTERVAL_SHORT = REFRESH_SHORT_CYC,
    parameter int BUSY_CYC = REFRESH_BUSY_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic short_sel,
    input wire logic access,
    output logic pending,
    output logic busy,
    output logic strobe
);
    logic [11:0] tmr_reg;
    logic [7:0] busy_cnt_reg;
    logic due_reg, busy_reg, strobe_reg;
    logic [11:0] limit;
    logic start;

    if (INTERVAL_SHORT > INTERVAL_LONG || INTERVAL_LONG > 4095 || BUSY_CYC < 1 || BUSY_CYC > 255
        || BUSY_CYC >= INTERVAL_SHORT)
    begin : g_chk
        $error("opc_refresh interval or busy count out of range");
    end

    assign limit = short_sel ? 12'(INTERVAL_SHORT - 1) : 12'(INTERVAL_LONG - 1);
    // a due refresh waits for the access to end
    assign start = due_reg && !busy_reg && !access; // RULE15

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable)
        begin
            tmr_reg <= 12'h000;
            due_reg <= 1'b0;
        end
        else if (tmr_reg >= limit)
        begin
            tmr_reg <= 12'h000;
            due_reg <= 1'b1;
        end
        else
        begin
            tmr_reg <= tmr_reg + 12'h001;
            if (start)
                due_reg <= 1'b0;
        end
    end

    // disabling aborts a refresh in flight
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable)
        begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= 8'h00;
            strobe_reg <= 1'b0;
        end
        else
        begin
            strobe_reg <= start;
            if (start)
            begin
                busy_reg <= 1'b1;
                busy_cnt_reg <= 8'(BUSY_CYC - 1);
            end
            else if (busy_reg)
            begin
                if (busy_cnt_reg == 8'h00)
                    busy_reg <= 1'b0;
                else
                    busy_cnt_reg <= busy_cnt_reg - 8'h01;
            end
        end
    end

    assign pending = due_reg || busy_reg;
    assign busy = busy_reg;
    assign strobe = strobe_reg;

    a_refresh_not_access: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE15
        $rose(busy_reg) |-> $past(!access))
        else $error("refresh started during an access");
endmodule // opc_refresh

// ==== opc_host.sv ====
// host controller model: select and link clock
// assumes the bench raises sel for each frame
`timescale 1ns/10ps
module opc_host
(
    input wire logic sel,
    output logic cs_pin_n,
    output logic ck_pin,
    output logic ck_n_pin
);
    initial
    begin
        ck_pin = 1'b0;
        forever
        begin
            #40;
            ck_pin = sel ? ~ck_pin : 1'b0; // stands low between frames
        end
    end
    assign cs_pin_n = ~sel;
    assign ck_n_pin = ~ck_pin;
    // no strobe pin driven, so latency turnaround stays free
endmodule // opc_host

// ==== testbench.sv ====
// self-checking bench for opc_psram_cfg with a host model
// assumes opc_pkg, the design files and opc_host compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t %h/%h", $time, g, e); end end
module testbench;
    import opc_pkg::*;
    logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sel = 0, hw_n = 1, hot = 0, rds = 0;
    logic [3:0] ra = '0;
    logic [15:0] wd = '0;
    logic [15:0] d;
    opc_phase_e ph = PH_IDLE;
    opc_phase_e seq [8] = '{PH_CA, PH_RD_LAT, PH_RD_DATA, PH_CA, PH_WR_LAT, PH_WR_DATA, PH_CA, PH_WR_ZERO};
    logic [2:0] ex [8] = '{3'h6, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0, 3'h6, 3'h4};
    int mismatches = 0, checks_done = 0, n_ref = 0, n_ck = 0, i;
    wire rwds_out, rwds_oe, dq_oe, ck_rise, ck_n_enable, burst_linear, clock_single, refresh_strobe;
    wire refresh_busy, latency_double, deep_power_down, hybrid_sleep, array_valid, cs_n, ck, ckn;
    wire [2:0] refresh_region;
    wire [15:0] reg_rdata;
    opc_psram_cfg opc_psram_cfg_i (.sys_clk, .rst_b, .reg_addr(ra), .reg_wdata(wd), .reg_wr, .reg_rd,
        .reg_rdata, .cs_pin_n(cs_n), .ck_pin(ck), .ck_n_pin(ckn), .hw_reset_pin_n(hw_n), .high_temp(hot),
        .phase(ph), .rd_strobe(rds), .rwds_out, .rwds_oe, .dq_oe, .ck_rise, .ck_n_enable, .burst_linear,
        .clock_single, .refresh_region, .refresh_strobe, .refresh_busy, .latency_double,
        .deep_power_down, .hybrid_sleep, .array_valid);
    opc_host opc_host_i (.sel, .cs_pin_n(cs_n), .ck_pin(ck), .ck_n_pin(ckn));
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (refresh_strobe) n_ref++;
    always @(posedge sys_clk) if (ck_rise) n_ck++;
////////////////////////////////////////
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        ra <= a;
        wd <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        ra <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task tally_and_finish;
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
////////////////////////////////////////
    initial
    begin
        #500us;
        mismatches++;
        tally_and_finish;
    end
    initial
    begin
        i = $urandom(32'h747c);
        cyc(20);
        rst_b <= 1'b1;
        rd(CFG1_ADDR, 16'hffc1);
        rd(CFG0_ADDR, 16'h8008);
        rd(4'h7, 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            d = {8'hff, 2'($urandom), 1'b0, 3'(i), 2'b10};
            wr(CFG1_ADDR, d);
            rd(CFG1_ADDR, {d[15:2], INTV_4US});
            `CHK({burst_linear, clock_single, ck_n_enable, refresh_region}, {d[7:6], ~d[6], d[4:2]})
        end
        wr(4'h7, 16'h0000);
        hot <= 1'b1;
        cyc(2);
        rd(CFG1_ADDR, {d[15:2], INTV_1US});
        hot <= 1'b0;
        sel <= 1'b1;
        cyc(8);
        for (i = 0; i < 8; i++)
        begin
            rds <= 1'($urandom);
            ph <= seq[i];
            cyc(2);
            #1;
            `CHK({rwds_oe, rwds_oe & rwds_out, dq_oe}, ex[i] | {1'b0, rds & (seq[i] == PH_RD_DATA), 1'b0})
        end
        `CHK(n_ck > 0, 1'b1)
        ph <= PH_IDLE;
        sel <= 1'b0;
        cyc(8);
        `CHK({rwds_oe, dq_oe}, 2'b00)
        i = n_ref;
        cyc(450);
        `CHK(n_ref > i, 1'b1)
        wr(CFG1_ADDR, 16'hff60);
        cyc(3);
        `CHK(hybrid_sleep, 1'b1)
        sel <= 1'b1;
        cyc(8);
        `CHK(hybrid_sleep, 1'b0)
        sel <= 1'b0;
        cyc(8);
        rd(CFG1_ADDR, 16'hff41);
        hw_n <= 1'b0;
        cyc(8);
        `CHK({burst_linear, clock_single, refresh_region, rwds_oe}, 6'h30)
        hw_n <= 1'b1;
        cyc(8);
        // fixed latency off, refresh region none: no reason for a high strobe
        wr(CFG0_ADDR, 16'h8000);
        wr(CFG1_ADDR, 16'hffd0);
        sel <= 1'b1;
        cyc(8);
        ph <= PH_CA;
        cyc(2);
        #1;
        `CHK({rwds_oe, rwds_out, latency_double}, 3'h4)
        ph <= PH_WR_ZERO;
        cyc(2);
        ph <= PH_IDLE;
        sel <= 1'b0;
        cyc(8);
        `CHK(array_valid, 1'b1)
        wr(CFG1_ADDR, 16'hffc0);
        wr(CFG0_ADDR, 16'h0008);
        cyc(DPD_ENTRY_CYC + 4);
        `CHK(deep_power_down, 1'b1)
        i = n_ref;
        wr(CFG1_ADDR, 16'hff00);
        cyc(450);
        `CHK({n_ref == i, refresh_busy}, 2'b10)
        i = n_ck;
        sel <= 1'b1;
        cyc(30);
        sel <= 1'b0;
        cyc(8);
        `CHK({deep_power_down, array_valid}, 2'b00)
        `CHK(n_ck, i)
        rd(CFG1_ADDR, 16'hffc1);
        tally_and_finish;
    end
endmodule // testbench
